// File: logic/flash_cmd_unlock_ctrl.sv
/*
  Command and status front end of the on-chip flash controller.
  Holds the write-only command register and read-only status register
  at one address, the page choice register and the sector protect
  register at another, tracks the unlock sequence and starts erases.
  Assumes register accesses come from the CPU core or the debugger on
  this clock, one access per cycle, with debug_access marking those
  issued by the debugger; the flash array reports erase completion and
  byte programming activity.
  Sector layout is not decoded here; protect bits are held and reported only.
*/
`timescale 1ns/10ps
`default_nettype none
`include "flash_cmd_regs.svh"

// Operation
// - Unlock only after 73H then 8CH on consecutive command writes.
// - Page erase starts only on 95H directly after both unlock bytes.
// - Mass erase starts only on 63H directly after both unlock bytes.
// - Mass erase honoured only from the debugger, never from the CPU.
// - Outside an erase, unknown or misordered command bytes return the controller to locked.
// - Page erase affects only the page held in the page field.
// - Writes to FF8H hit the command register; reads return status.
// - Command 5EH written while locked routes later page choice accesses to sector protect.
// - Status reads at any time, without side effects, show current state.
// - Status 5:0 codes locked, first, second, unlocked, protect selected.
// - Busy codes 001xxx program, 010xxx page erase, 100xxx mass erase.
// - Status bits 7 and 6 read as zero.
// - FF9H writes update page choice unless protect was selected or an erase runs.
// - 512-byte pages; page field equals program address bits 15:9.
// - Page choice bit 7 maps the information area at FE00H-FFFFH.
// - User writes to sector protect can only set bits.
// - A finished page or mass erase returns the controller to locked.
// - While unlocked, any non-erase command ends programming and locks.
module flash_cmd_unlock_ctrl #(
  parameter int ADDR_W = 12,
  parameter int DATA_W = 8,
  parameter int PROG_ADDR_W = 16
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic debug_access,
  input wire logic [PROG_ADDR_W-1:0] prog_addr,
  input wire logic byte_prog_busy,
  input wire logic erase_done,
  output logic [DATA_W-1:0] reg_rdata,
  output logic page_erase_start,
  output logic mass_erase_start,
  output logic erase_busy,
  output logic prog_enable,
  output logic info_area_map_enable,
  output logic info_area_hit,
  output logic [6:0] erase_page,
  output logic [DATA_W-1:0] sector_protect
);

  flash_ctl_if ctl ();

  flash_cmd_pkg::ctrl_state_t state_r;
  flash_cmd_pkg::ctrl_state_t state_nxt;

  logic [DATA_W-1:0] page_choice_r;
  logic [DATA_W-1:0] protect_r;
  logic [DATA_W-1:0] rdata_r;
  logic [DATA_W-1:0] status_byte;
  logic [5:0] status_code;
  logic [6:0] erase_page_r;
  logic page_start_r;
  logic mass_start_r;
  logic erase_busy_r;
  logic prog_enable_r;
  logic info_map_r;
  logic info_hit_r;
  logic debug_unlock_r;
  logic page_entry;
  logic mass_entry;
  logic cmd_wr;
  logic page_wr;
  logic cmd_rd;
  logic page_rd;

  // Access decode on the two shared addresses
  // write port versus read port
  assign cmd_wr = reg_wr && (reg_addr == `FLASH_COMMAND_ADDR);
  assign page_wr = reg_wr && (reg_addr == `FLASH_PAGE_CHOICE_ADDR);
  assign cmd_rd = reg_rd && (reg_addr == `FLASH_COMMAND_ADDR);
  assign page_rd = reg_rd && (reg_addr == `FLASH_PAGE_CHOICE_ADDR);

  // Feed the decoder and page map
  assign ctl.command_byte = reg_wdata;
  assign ctl.page_choice = page_choice_r;
  assign ctl.prog_addr = prog_addr;

  flash_cmd_decode u_decode (
    .bus(ctl.decode)
  );

  flash_page_map u_map (
    .bus(ctl.map)
  );

  // Next state from command writes, page unlock and erase completion
  always_comb
  begin
    state_nxt = state_r;
    unique case (state_r)
      flash_cmd_pkg::ST_LOCKED:
      begin
        if (cmd_wr)
        begin
          if (ctl.cmd_kind == flash_cmd_pkg::CK_UNLOCK_FIRST)
            state_nxt = flash_cmd_pkg::ST_UNLOCK_FIRST;
          else if (ctl.cmd_kind == flash_cmd_pkg::CK_PROTECT_SEL)
            state_nxt = flash_cmd_pkg::ST_PROTECT_SEL;
          else
            state_nxt = flash_cmd_pkg::ST_LOCKED;
        end
      end
      flash_cmd_pkg::ST_UNLOCK_FIRST:
      begin
        if (cmd_wr)
        begin
          // second byte must follow at once
          if (ctl.cmd_kind == flash_cmd_pkg::CK_UNLOCK_SECOND)
            state_nxt = flash_cmd_pkg::ST_UNLOCK_SECOND;
          else
            state_nxt = flash_cmd_pkg::ST_LOCKED;
        end
      end
      flash_cmd_pkg::ST_UNLOCK_SECOND, flash_cmd_pkg::ST_UNLOCKED:
      begin
        if (cmd_wr)
        begin
          if (ctl.cmd_kind == flash_cmd_pkg::CK_PAGE_ERASE)
            state_nxt = flash_cmd_pkg::ST_PAGE_ERASE;
          else if (ctl.cmd_kind == flash_cmd_pkg::CK_MASS_ERASE && debug_access)
            state_nxt = flash_cmd_pkg::ST_MASS_ERASE;
          else
            state_nxt = flash_cmd_pkg::ST_LOCKED;
        end
        else if (page_wr && state_r == flash_cmd_pkg::ST_UNLOCK_SECOND)
        begin
          // Page choice write completes the page unlock
          state_nxt = flash_cmd_pkg::ST_UNLOCKED;
        end
      end
      flash_cmd_pkg::ST_PROTECT_SEL:
      begin
        // Only a repeated 5EH keeps protect selected
        if (cmd_wr && ctl.cmd_kind != flash_cmd_pkg::CK_PROTECT_SEL)
          state_nxt = flash_cmd_pkg::ST_LOCKED;
      end
      flash_cmd_pkg::ST_PAGE_ERASE, flash_cmd_pkg::ST_MASS_ERASE:
      begin
        if (erase_done)
          state_nxt = flash_cmd_pkg::ST_LOCKED;
      end
    endcase
  end

  // Controller state register
  always_ff @(posedge clock)
  begin
    if (!rstn)
      state_r <= flash_cmd_pkg::ST_LOCKED;
    else
      state_r <= state_nxt;
  end

  // Debugger unlock lifts the page limit on programming
  // Taken from the command write after 73H, even one that relocks; dropped on any other relock
  always_ff @(posedge clock)
  begin
    if (!rstn)
      debug_unlock_r <= 1'b0;
    else if (cmd_wr && state_r == flash_cmd_pkg::ST_UNLOCK_FIRST)
      debug_unlock_r <= debug_access;
    else if (state_nxt == flash_cmd_pkg::ST_LOCKED)
      debug_unlock_r <= 1'b0;
  end

  // Page choice register; writes are refused while an erase runs
  // Refusal keeps the page and the map steady under a running erase
  always_ff @(posedge clock)
  begin
    if (!rstn)
      page_choice_r <= `PAGE_CHOICE_RESET;
    else if (page_wr && state_r != flash_cmd_pkg::ST_PROTECT_SEL
             && !erase_busy_r)
      page_choice_r <= reg_wdata;
  end

  // Sector protect register, cleared by reset or by a debugger write
  // A debugger write may clear bits, so it replaces the value outright
  always_ff @(posedge clock)
  begin
    if (!rstn)
      protect_r <= `PROTECT_RESET;
    // reached through the page choice address
    else if (page_wr && state_r == flash_cmd_pkg::ST_PROTECT_SEL)
    begin
      // user code only sets bits; debugger writes freely
      if (debug_access)
        protect_r <= reg_wdata;
      else
        protect_r <= protect_r | reg_wdata;
    end
  end

  // Entry into an erase state, shared by start pulse and page capture
  assign page_entry = (state_nxt == flash_cmd_pkg::ST_PAGE_ERASE)
                      && (state_r != flash_cmd_pkg::ST_PAGE_ERASE);
  assign mass_entry = (state_nxt == flash_cmd_pkg::ST_MASS_ERASE)
                      && (state_r != flash_cmd_pkg::ST_MASS_ERASE);

  // Erase start pulses, one cycle each
  always_ff @(posedge clock)
  begin
    if (!rstn)
    begin
      page_start_r <= 1'b0;
      mass_start_r <= 1'b0;
    end
    else
    begin
      page_start_r <= page_entry;
      mass_start_r <= mass_entry;
    end
  end

  // Captured page, held for the whole erase so no later write retargets it
  always_ff @(posedge clock)
  begin
    if (!rstn)
      erase_page_r <= `ERASE_PAGE_RESET;
    // erase targets the page held now
    else if (page_entry)
      erase_page_r <= page_choice_r[`PAGE_FIELD_MSB:0];
  end

  // Erase busy, set with the start pulse and dropped on the done edge
  always_ff @(posedge clock)
  begin
    if (!rstn)
      erase_busy_r <= 1'b0;
    else
      erase_busy_r <= (state_nxt == flash_cmd_pkg::ST_PAGE_ERASE)
                      || (state_nxt == flash_cmd_pkg::ST_MASS_ERASE);
  end

  // Programming window
  always_ff @(posedge clock)
  begin
    if (!rstn)
      prog_enable_r <= 1'b0;
    // user programming confined to the chosen page
    else
      prog_enable_r <= (state_nxt == flash_cmd_pkg::ST_UNLOCKED)
                       && (ctl.in_page || debug_unlock_r);
  end

  // Information area mapping
  // Hit is registered beside the map bit so both move on one edge
  always_ff @(posedge clock)
  begin
    if (!rstn)
    begin
      info_map_r <= 1'b0;
      info_hit_r <= 1'b0;
    end
    else
    begin
      info_map_r <= page_choice_r[`PAGE_CHOICE_INFO_BIT];
      info_hit_r <= ctl.in_info;
    end
  end

  // Status code from the current state
  always_comb
  begin
    status_code = `STAT_LOCKED;
    unique case (state_r)
      flash_cmd_pkg::ST_LOCKED: status_code = `STAT_LOCKED;
      flash_cmd_pkg::ST_UNLOCK_FIRST: status_code = `STAT_UNLOCK_FIRST;
      flash_cmd_pkg::ST_UNLOCK_SECOND: status_code = `STAT_UNLOCK_SECOND;
      flash_cmd_pkg::ST_PROTECT_SEL: status_code = `STAT_PROTECT_SEL;
      flash_cmd_pkg::ST_UNLOCKED:
        status_code = byte_prog_busy ? `STAT_BYTE_PROG : `STAT_UNLOCKED;
      flash_cmd_pkg::ST_PAGE_ERASE: status_code = `STAT_PAGE_ERASE;
      flash_cmd_pkg::ST_MASS_ERASE: status_code = `STAT_MASS_ERASE;
    endcase
  end

  assign status_byte = {`STAT_RESERVED, status_code};

  // Read data, one cycle after the read; reads change no state
  // Idle value is zero so a quiet bus shows nothing stale
  always_ff @(posedge clock)
  begin
    if (!rstn)
      rdata_r <= `READ_IDLE;
    else if (cmd_rd)
      rdata_r <= status_byte;
    else if (page_rd && state_r == flash_cmd_pkg::ST_PROTECT_SEL)
      rdata_r <= protect_r;
    else if (page_rd)
      rdata_r <= page_choice_r;
    else
      rdata_r <= `READ_IDLE;
  end

  // Outputs straight from flops
  assign reg_rdata = rdata_r;
  assign page_erase_start = page_start_r;
  assign mass_erase_start = mass_start_r;
  assign erase_busy = erase_busy_r;
  assign prog_enable = prog_enable_r;
  assign info_area_map_enable = info_map_r;
  assign info_area_hit = info_hit_r;
  assign erase_page = erase_page_r;
  assign sector_protect = protect_r;

endmodule

`default_nettype wire

// File: inc/flash_cmd_regs.svh
/*
  Register addresses, command codes, status codes and field positions
  of the flash command and unlock front end. Definitions only.
*/
`ifndef FLASH_CMD_REGS_SVH
`define FLASH_CMD_REGS_SVH

// Register file addresses
`define FLASH_COMMAND_ADDR 12'hff8
`define FLASH_PAGE_CHOICE_ADDR 12'hff9

// Command bytes
`define CMD_UNLOCK_FIRST 8'h73
`define CMD_UNLOCK_SECOND 8'h8c
`define CMD_PAGE_ERASE 8'h95
`define CMD_MASS_ERASE 8'h63
`define CMD_PROTECT_SELECT 8'h5e

// Status field codes, bits 5:0
`define STAT_LOCKED 6'h00
`define STAT_UNLOCK_FIRST 6'h01
`define STAT_UNLOCK_SECOND 6'h02
`define STAT_UNLOCKED 6'h03
`define STAT_PROTECT_SEL 6'h04
`define STAT_BYTE_PROG 6'h08
`define STAT_PAGE_ERASE 6'h10
`define STAT_MASS_ERASE 6'h20
`define STAT_RESERVED 2'h0

// Page choice register layout and reset values
`define PAGE_CHOICE_INFO_BIT 7
`define PAGE_FIELD_MSB 6
`define PAGE_ADDR_MSB 15
`define PAGE_ADDR_LSB 9
`define INFO_AREA_BASE 16'hfe00
`define PAGE_CHOICE_RESET 8'h00
`define PROTECT_RESET 8'h00
`define ERASE_PAGE_RESET 7'h00
`define READ_IDLE 8'h00

`endif

// File: inc/flash_cmd_pkg.sv
/*
  Types shared by the flash command front end: controller states and
  command classes. Assumes nothing of its surroundings.
*/
`default_nettype none

package flash_cmd_pkg;

  // One-hot controller states
  typedef enum logic [6:0] {
    ST_LOCKED = 7'b0000001,
    ST_UNLOCK_FIRST = 7'b0000010,
    ST_UNLOCK_SECOND = 7'b0000100,
    ST_UNLOCKED = 7'b0001000,
    ST_PROTECT_SEL = 7'b0010000,
    ST_PAGE_ERASE = 7'b0100000,
    ST_MASS_ERASE = 7'b1000000
  } ctrl_state_t;

  // Decoded command byte
  typedef enum logic [2:0] {
    CK_UNLOCK_FIRST = 3'h0,
    CK_UNLOCK_SECOND = 3'h1,
    CK_PAGE_ERASE = 3'h2,
    CK_MASS_ERASE = 3'h3,
    CK_PROTECT_SEL = 3'h4,
    CK_OTHER = 3'h5
  } cmd_kind_t;

endpackage

`default_nettype wire

// File: inc/flash_ctl_if.sv
/*
  Carrier between the controller and its decoder and page map.
  Assumes all three sit on one clock; all signals are combinational.
*/
`timescale 1ns/10ps
`default_nettype none

interface flash_ctl_if;
  logic [7:0] command_byte;
  flash_cmd_pkg::cmd_kind_t cmd_kind;
  logic [7:0] page_choice;
  logic [15:0] prog_addr;
  logic in_page;
  logic in_info;

  modport ctrl (output command_byte, output page_choice, output prog_addr,
                input cmd_kind, input in_page, input in_info);
  modport decode (input command_byte, output cmd_kind);
  modport map (input page_choice, input prog_addr, output in_page, output in_info);
endinterface

`default_nettype wire

// File: logic/flash_cmd_decode.sv
/*
  Classifies a command byte into a command kind.
  Assumes the byte is stable while the controller samples the result.
*/
`timescale 1ns/10ps
`default_nettype none
`include "flash_cmd_regs.svh"

module flash_cmd_decode (
  flash_ctl_if.decode bus
);

  // Anything not listed is an invalid command
  always_comb
  begin
    unique case (bus.command_byte)
      `CMD_UNLOCK_FIRST: bus.cmd_kind = flash_cmd_pkg::CK_UNLOCK_FIRST;
      `CMD_UNLOCK_SECOND: bus.cmd_kind = flash_cmd_pkg::CK_UNLOCK_SECOND;
      `CMD_PAGE_ERASE: bus.cmd_kind = flash_cmd_pkg::CK_PAGE_ERASE;
      `CMD_MASS_ERASE: bus.cmd_kind = flash_cmd_pkg::CK_MASS_ERASE;
      `CMD_PROTECT_SELECT: bus.cmd_kind = flash_cmd_pkg::CK_PROTECT_SEL;
      default: bus.cmd_kind = flash_cmd_pkg::CK_OTHER;
    endcase
  end

endmodule

`default_nettype wire

// File: logic/flash_page_map.sv
/*
  Maps a program memory address against the page choice register:
  page membership and information area hit.
  Assumes a 16-bit program address and 512-byte pages.
*/
`timescale 1ns/10ps
`default_nettype none
`include "flash_cmd_regs.svh"

module flash_page_map (
  flash_ctl_if.map bus
);

  // Page is address bits 15:9; info area sits at the top 512 bytes
  always_comb
  begin
    bus.in_page = (bus.prog_addr[`PAGE_ADDR_MSB:`PAGE_ADDR_LSB]
                   == bus.page_choice[`PAGE_FIELD_MSB:0]);
    bus.in_info = bus.page_choice[`PAGE_CHOICE_INFO_BIT]
                  && (bus.prog_addr >= `INFO_AREA_BASE);
  end

endmodule

`default_nettype wire

// File: dv/flash_cmd_unlock_ctrl_assertions.sv
/*
  Port assertions for the flash command front end.
  Assumes a bind onto flash_cmd_unlock_ctrl, one clock domain.
*/
`timescale 1ns/10ps
`default_nettype none

module flash_cmd_unlock_ctrl_assertions (
  input wire logic clock,
  input wire logic rstn,
  input wire logic [11:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  input wire logic debug_access,
  input wire logic [15:0] prog_addr,
  input wire logic erase_done,
  input wire logic [7:0] reg_rdata,
  input wire logic page_erase_start,
  input wire logic mass_erase_start,
  input wire logic erase_busy,
  input wire logic info_area_map_enable,
  input wire logic info_area_hit,
  input wire logic [6:0] erase_page,
  input wire logic [7:0] sector_protect
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rstn);

  // Unknown byte, a quiet cycle, then a status read
  sequence s_bad_cmd;
    reg_wr && reg_addr == 12'hff8 && !erase_busy &&
      !(reg_wdata inside {8'h73, 8'h8c, 8'h95, 8'h63, 8'h5e});
  endsequence
  sequence s_stat_rd;
    reg_rd && reg_addr == 12'hff8;
  endsequence

  a_bad_locks: assert property (s_bad_cmd ##1 !reg_wr ##1 s_stat_rd |=> reg_rdata == 8'h00)
    else $error("status not locked after unknown byte");
  a_rsv_zero: assert property ($past(reg_rd && reg_addr == 12'hff8) |-> reg_rdata[7:6] == 2'b00)
    else $error("reserved status bits set");
  a_idle_read: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data without a read");
  a_page_cause: assert property (page_erase_start |-> $past(reg_wr && reg_addr == 12'hff8 && reg_wdata == 8'h95))
    else $error("page erase without its command");
  a_mass_debug: assert property (mass_erase_start |->
    $past(debug_access && reg_wr && reg_addr == 12'hff8 && reg_wdata == 8'h63))
    else $error("mass erase without debugger command");
  a_start_busy: assert property (page_erase_start || mass_erase_start |-> erase_busy && !$past(erase_busy))
    else $error("start pulse not with busy rise");
  a_done_lock: assert property (erase_busy && erase_done |=> !erase_busy)
    else $error("erase did not end on done");
  a_page_hold: assert property (erase_busy && !page_erase_start |-> $stable(erase_page))
    else $error("erase page moved during erase");
  a_protect_set: assert property ($past(rstn) && !$past(debug_access) |->
    (sector_protect | $past(sector_protect)) == sector_protect)
    else $error("protect bit cleared by user");
  a_info_hit: assert property (info_area_map_enable && $past(info_area_map_enable) && $past(rstn) |->
    info_area_hit == ($past(prog_addr) >= 16'hfe00))
    else $error("information area hit wrong");
endmodule

`default_nettype wire

// File: dv/flash_array_model.sv
/*
  Flash array stand-in answering each erase with a done pulse.
  Assumes erase_busy from the front end on the same clock.
*/
`timescale 1ns/10ps
`default_nettype none

module flash_array_model (
  input wire logic clock,
  input wire logic rstn,
  input wire logic erase_busy,
  input wire logic slow,
  output logic erase_done
);
  int cnt_r;

  // Erase time counter; slow mode stresses status polling
  always_ff @(posedge clock)
  begin
    if (!rstn || !erase_busy || erase_done)
    begin
      cnt_r <= 0;
      erase_done <= 1'b0;
    end
    else
    begin
      cnt_r <= cnt_r + 1;
      erase_done <= (cnt_r == (slow ? 40 : 6));
    end
  end
endmodule

`default_nettype wire

// File: dv/tb.sv
/*
  Self-checking bench for the flash command front end.
  Assumes the checker and array model files compile first.
*/
`timescale 1ns/10ps
`default_nettype none

module tb;
  logic clock = 1'b0;
  logic rstn = 1'b0;
  logic [11:0] reg_addr = 12'h000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_wdata = 8'h00;
  logic debug_access = 1'b0;
  logic [15:0] prog_addr = 16'h0000;
  logic byte_prog_busy = 1'b0;
  logic slow = 1'b0;
  logic erase_done;
  logic [7:0] reg_rdata;
  logic page_erase_start;
  logic mass_erase_start;
  logic erase_busy;
  logic prog_enable;
  logic info_area_map_enable;
  logic info_area_hit;
  logic [6:0] erase_page;
  logic [7:0] sector_protect;
  logic [31:0] seed = 32'haaf4;
  int errors = 0;
  int checks_done = 0;
  int st = 0;
  int pg = 0;
  int prot = 0;

  // Clock, design and array
  always #10 clock = ~clock;
  flash_cmd_unlock_ctrl uut (
    .clock(clock),
    .rstn(rstn),
    .reg_addr(reg_addr),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_wdata(reg_wdata),
    .debug_access(debug_access),
    .prog_addr(prog_addr),
    .byte_prog_busy(byte_prog_busy),
    .erase_done(erase_done),
    .reg_rdata(reg_rdata),
    .page_erase_start(page_erase_start),
    .mass_erase_start(mass_erase_start),
    .erase_busy(erase_busy),
    .prog_enable(prog_enable),
    .info_area_map_enable(info_area_map_enable),
    .info_area_hit(info_area_hit),
    .erase_page(erase_page),
    .sector_protect(sector_protect)
  );
  flash_array_model far (.clock(clock), .rstn(rstn), .erase_busy(erase_busy), .slow(slow),
    .erase_done(erase_done));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic finish_test();
    $display("Checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // One read strobe; data lands the cycle after
  task automatic rd(input logic [11:0] a, input logic [7:0] exp, input string what);
    @(posedge clock);
    #1 reg_rd = 1'b1;
    reg_addr = a;
    @(posedge clock);
    #1 reg_rd = 1'b0;
    chk(what, reg_rdata, exp);
  endtask

  // One write, then the bench model steps and is compared
  task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic dbg);
    logic pe;
    logic me;
    @(posedge clock);
    #1 reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    debug_access = dbg;
    @(posedge clock);
    #1 reg_wr = 1'b0;
    debug_access = 1'b0;
    pe = (st == 2 || st == 3) && a == 12'hff8 && d == 8'h95;
    me = (st == 2 || st == 3) && a == 12'hff8 && d == 8'h63 && dbg;
    if (a == 12'hff9)
    begin
      if (st == 4)
        prot = dbg ? d : (prot | d);
      else
        pg = d;
      if (st == 2)
        st = 3;
    end
    else
      st = pe ? 16 : me ? 32 : (st == 0 && d == 8'h73) ? 1 : (st == 1 && d == 8'h8c) ? 2 :
        (st == 0 && d == 8'h5e) ? 4 : 0;
    chk("page start", page_erase_start, pe);
    chk("mass start", mass_erase_start, me);
    chk("protect", sector_protect, prot[7:0]);
    if (pe)
      chk("erase page", erase_page, pg[6:0]);
    rd(12'hff8, st[7:0], "status");
    // Map bit trails the page choice by one edge
    chk("map enable", info_area_map_enable, pg[7]);
  endtask

  // every erase in this bench follows this unlock

  task automatic unlock(input logic [7:0] p);
    wr(12'hff8, 8'h73, 1'b0);
    wr(12'hff8, 8'h8c, 1'b0);
    wr(12'hff9, p, 1'b0);
  endtask

  // Bounded wait for the erase to finish
  task automatic wait_idle();
    int n;
    for (n = 0; n < 100 && erase_busy !== 1'b0; n++)
      #20;
    if (n == 100)
    begin
      errors++;
      finish_test();
    end
    st = 0;
    rd(12'hff8, 8'h00, "status");
  endtask

  initial
  begin
    repeat (20) @(posedge clock);
    #1 rstn = 1'b1;
    rd(12'hff8, 8'h00, "status");
    rd(12'hff9, 8'h00, "page choice");
    rd(12'h123, 8'h00, "unmapped");
    // Every erase command and source, slow array chosen on each pass by seed bit 9
    for (int i = 0; i < 4; i++)
    begin
      seed = lfsr(seed);
      slow = seed[9];
      unlock(seed[7:0]);
      rd(12'hff9, seed[7:0], "page choice");
      prog_addr = {seed[6:0], seed[24:16]};
      rd(12'hff8, 8'h03, "status");
      chk("prog enable", prog_enable, 1'b1);
      chk("info hit", info_area_hit, seed[7] && seed[6:0] == 7'h7f);
      prog_addr[15:9] = ~prog_addr[15:9];
      byte_prog_busy = 1'b1;
      rd(12'hff8, 8'h08, "status");
      chk("prog enable", prog_enable, 1'b0);
      byte_prog_busy = 1'b0;
      wr(12'hff8, i[0] ? 8'h95 : 8'h63, i[1]);
      wait_idle();
    end
    // Misordered unlock bytes
    wr(12'hff8, 8'h8c, 1'b0);
    wr(12'hff8, 8'h73, 1'b0);
    wr(12'hff8, 8'h73, 1'b0);
    // Debugger unlock lifts the page limit; page field held at zero, info area mapped
    wr(12'hff8, 8'h73, 1'b0);
    wr(12'hff8, 8'h8c, 1'b1);
    wr(12'hff9, 8'h80, 1'b0);
    prog_addr = 16'hfe40;
    rd(12'hff8, 8'h03, "status");
    chk("prog enable", prog_enable, 1'b1);
    chk("info hit", info_area_hit, 1'b1);
    wr(12'hff8, 8'h11, 1'b0);
    // Protect select: user sets only, debugger replaces
    wr(12'hff8, 8'h5e, 1'b0);
    for (int i = 0; i < 3; i++)
    begin
      seed = lfsr(seed);
      wr(12'hff9, seed[7:0], 1'b0);
    end
    rd(12'hff9, prot[7:0], "protect");
    wr(12'hff9, 8'h0a, 1'b1);
    wr(12'hff8, 8'h00, 1'b0);
    rd(12'hff9, pg[7:0], "page choice");
    // Reset in mid-sequence
    wr(12'hff8, 8'h73, 1'b0);
    @(posedge clock);
    #1 rstn = 1'b0;
    @(posedge clock);
    #1 rstn = 1'b1;
    st = 0;
    pg = 0;
    prot = 0;
    rd(12'hff8, 8'h00, "status");
    chk("protect", sector_protect, 8'h00);
    finish_test();
  end
endmodule

bind flash_cmd_unlock_ctrl flash_cmd_unlock_ctrl_assertions chk_ports (
  .clock(clock),
  .rstn(rstn),
  .reg_addr(reg_addr),
  .reg_wr(reg_wr),
  .reg_rd(reg_rd),
  .reg_wdata(reg_wdata),
  .debug_access(debug_access),
  .prog_addr(prog_addr),
  .erase_done(erase_done),
  .reg_rdata(reg_rdata),
  .page_erase_start(page_erase_start),
  .mass_erase_start(mass_erase_start),
  .erase_busy(erase_busy),
  .info_area_map_enable(info_area_map_enable),
  .info_area_hit(info_area_hit),
  .erase_page(erase_page),
  .sector_protect(sector_protect)
);

`default_nettype wire
